// ==== common/crl_pkg.sv ====
// Constants, register map and carrier types for the refrigeration output logic
package crl_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PCT_W = 7;
  localparam int TEMP_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CHAN_LVL = 8'h00;
  localparam logic [7:0] OFS_STAGE_LVL = 8'h04;
  localparam logic [7:0] OFS_AMB_LVL = 8'h08;
  localparam logic [7:0] OFS_CUTOFF = 8'h0c;
  localparam logic [7:0] OFS_DELAY = 8'h10;
  localparam logic [7:0] OFS_CYCLE = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Field positions: on level low byte, off level second byte
  localparam int LVL_ON_LSB = 0;
  localparam int LVL_OFF_LSB = 8;
  localparam int CUT_LSB = 0;
  localparam int OFFDLY_LSB = 0;
  localparam int OFFDLY_W = 3;
  localparam int BOOST_LSB = 8;
  localparam int BOOST_W = 8;
  localparam int CYC_W = 6;
  localparam int CYC_HUM_LSB = 0;
  localparam int CYC_AHEAT_LSB = 8;
  localparam int CYC_ACOOL_LSB = 16;
  localparam int MODE_PURGE_BIT = 0;
  localparam int MODE_BOOST_BIT = 1;
  localparam int MODE_AMB_TP_BIT = 2;
  localparam int MODE_LEV2_BIT = 3;

  // Writable bits of each register; the rest read as zero
  localparam logic [31:0] MASK_LVL = 32'h0000_7f7f;
  localparam logic [31:0] MASK_CUTOFF = 32'h0000_00ff;
  localparam logic [31:0] MASK_DELAY = 32'h0000_ff07;
  localparam logic [31:0] MASK_CYCLE = 32'h003f_3f3f;
  localparam logic [31:0] MASK_MODE = 32'h0000_000f;

  // Reset values
  localparam logic [31:0] RST_CHAN_LVL = 32'h0000_320a;
  localparam logic [31:0] RST_STAGE_LVL = 32'h0000_5014;
  localparam logic [31:0] RST_AMB_LVL = 32'h0000_320a;
  localparam logic [31:0] RST_CUTOFF = 32'h0000_0032;
  localparam logic [31:0] RST_DELAY = 32'h0000_1e01;
  localparam logic [31:0] RST_CYCLE = 32'h0007_0101;
  localparam logic [31:0] RST_MODE = 32'h0000_0000;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CENTI_TICK_NS = 10_000_000;
  localparam int CENTI_CYCLES = CENTI_TICK_NS / CLK_PERIOD_NS;
  localparam int CENTI_PER_SEC = 100;
  localparam int SEC_PER_MIN = 60;
  localparam int HS_ON_DELAY_S = 60;
  localparam logic [6:0] PCT_FULL = 7'h64;

  // PID outputs of one channel
  typedef struct packed {
    logic [6:0] cool_pct;
    logic [6:0] heat_pct;
  } crl_pid_s;

  // Compressor sequencing
  typedef enum logic [1:0] {
    COMP_OFF,
    COMP_RUN,
    COMP_HOLD
  } crl_comp_e;

endpackage : crl_pkg

// ==== hdl/crl_output_logic.sv ====
// Refrigeration, vacuum, vent, humidify and ambient output decision logic
//
// Summary of operation
// [RQ1] Compressor on when cooling reaches on level
// [RQ2] Compressor off when heating reaches off level
// [RQ3] Ramping up past cutoff temperature stops cooling
// [RQ4] Off delay in minutes before compressor stops
// [RQ5] Heating direction only while profile ramps
// [RQ6] Single and low stage: on wins
// [RQ7] Low stage on at channel 1 cooling level
// [RQ8] Low stage off at channel 1 heating level
// [RQ9] Cooling above zero resets off-delay timer
// [RQ10] High stage waits one minute after request
// [RQ11] Cut-in contact selects pressure switch gating
// [RQ12] Cascade condenser feeds liquid when cooling needed
// [RQ13] Cascade condenser: off wins
// [RQ14] Vacuum output type vacuum or purge
// [RQ15] Purge type follows event level two
// [RQ16] Vent or boost cool, simple on/off
// [RQ17] Boost cool after delay in seconds
// [RQ18] Boost timer reset below full cooling
// [RQ19] Humidify time proportioned, 1-60 s cycle
// [RQ20] Ambient output proportioned or on/off
// [RQ21] Ambient on/off by its cool/heat levels
// [RQ22] Ambient cycles: heat 1 s, cool 7 s
// [RQ23] All delays from divided clock tick
// [RQ24] Low artificial load inverts PID cool
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Time-proportioning stage: on for pct percent of each cycle
module crl_tp (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_centi,
  input wire logic [5:0] i_cycle_s,
  input wire logic [6:0] i_pct,
  output logic o_on
);
  import crl_pkg::*;
  logic [12:0] phase_r;
  logic [12:0] limit;
  logic [12:0] duty;

  // Cycle length and on time in centiseconds
  assign limit = 13'({7'h00, i_cycle_s} * 13'(CENTI_PER_SEC));
  assign duty = 13'({6'h00, i_pct} * {7'h00, i_cycle_s});

  // Phase counter wraps each cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_r <= 13'h0000;
    end else if (i_centi) begin
      if (phase_r + 13'h0001 >= limit) begin
        phase_r <= 13'h0000;
      end else begin
        phase_r <= phase_r + 13'h0001;
      end
    end
  end

  // Output registered from phase compare
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_on <= 1'b0;
    end else begin
      o_on <= (phase_r < duty);
    end
  end
endmodule : crl_tp

////////////////////////////////////////////////////////////////////////////////
// Top level
module crl_output_logic #(
  parameter int CENTI_CYC = crl_pkg::CENTI_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [crl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [crl_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [crl_pkg::DATA_W-1:0] o_rdata,
  input wire crl_pkg::crl_pid_s i_chan1,
  input wire crl_pkg::crl_pid_s i_chan2,
  input wire logic [crl_pkg::PCT_W-1:0] i_humid_pct,
  input wire logic [crl_pkg::TEMP_W-1:0] i_temp,
  input wire logic i_profile_ramping,
  input wire logic i_sp_rising,
  input wire logic i_pid_cool,
  input wire logic i_vacuum_req,
  input wire logic i_vent_req,
  input wire logic i_cutin_closed,
  input wire logic i_pressure_ok,
  output logic [1:0] o_compressor,
  output logic o_low_stage,
  output logic o_high_stage,
  output logic o_cascade_cond,
  output logic o_vacuum,
  output logic o_vent_boost,
  output logic o_humidify,
  output logic o_ambient,
  output logic o_low_art_load
);
  import crl_pkg::*;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] chan_lvl_r, stage_lvl_r, amb_lvl_r, cutoff_r, delay_r, cycle_r, mode_r;

  // Software writes, masked to the defined fields
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      chan_lvl_r <= RST_CHAN_LVL;
      stage_lvl_r <= RST_STAGE_LVL;
      amb_lvl_r <= RST_AMB_LVL;
      cutoff_r <= RST_CUTOFF;
      delay_r <= RST_DELAY;
      cycle_r <= RST_CYCLE;
      mode_r <= RST_MODE;
    end else if (i_wr) begin
      unique case (i_addr)
        OFS_CHAN_LVL: chan_lvl_r <= i_wdata & MASK_LVL;
        OFS_STAGE_LVL: stage_lvl_r <= i_wdata & MASK_LVL;
        OFS_AMB_LVL: amb_lvl_r <= i_wdata & MASK_LVL;
        OFS_CUTOFF: cutoff_r <= i_wdata & MASK_CUTOFF;
        OFS_DELAY: delay_r <= i_wdata & MASK_DELAY;
        OFS_CYCLE: cycle_r <= i_wdata & MASK_CYCLE;
        OFS_MODE: mode_r <= i_wdata & MASK_MODE;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        OFS_CHAN_LVL: o_rdata <= chan_lvl_r;
        OFS_STAGE_LVL: o_rdata <= stage_lvl_r;
        OFS_AMB_LVL: o_rdata <= amb_lvl_r;
        OFS_CUTOFF: o_rdata <= cutoff_r;
        OFS_DELAY: o_rdata <= delay_r;
        OFS_CYCLE: o_rdata <= cycle_r;
        OFS_MODE: o_rdata <= mode_r;
        OFS_STATUS: o_rdata <= {22'h00_0000, o_low_art_load, o_ambient, o_humidify,
          o_vent_boost, o_vacuum, o_cascade_cond, o_high_stage, o_low_stage, o_compressor};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Field views
  logic [2:0] off_delay_min;
  logic [7:0] boost_delay_s;
  assign off_delay_min = delay_r[OFFDLY_LSB +: OFFDLY_W];
  assign boost_delay_s = delay_r[BOOST_LSB +: BOOST_W];

  //////////////////////////////////////////////////////////////////////////////
  // Contact input synchronisers
  logic [1:0] cutin_sync_r, press_sync_r;
  logic cutin, press_ok;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cutin_sync_r <= 2'h0;
      press_sync_r <= 2'h0;
    end else begin
      cutin_sync_r <= {cutin_sync_r[0], i_cutin_closed};
      press_sync_r <= {press_sync_r[0], i_pressure_ok};
    end
  end
  assign cutin = cutin_sync_r[1];
  assign press_ok = press_sync_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // Time base
  logic [$clog2(CENTI_CYC)-1:0] div_r;
  logic [6:0] centi_r;
  logic [5:0] sec_r;
  logic centi_tick, sec_tick, min_tick;

  // [RQ23] divided tick chain
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_r <= '0;
      centi_r <= 7'h00;
      sec_r <= 6'h00;
    end else begin
      div_r <= centi_tick ? '0 : div_r + 1'b1;
      if (centi_tick) begin
        centi_r <= sec_tick ? 7'h00 : centi_r + 7'h01;
      end
      if (sec_tick) begin
        sec_r <= min_tick ? 6'h00 : sec_r + 6'h01;
      end
    end
  end
  assign centi_tick = (div_r == ($clog2(CENTI_CYC))'(CENTI_CYC - 1));
  assign sec_tick = centi_tick && (centi_r == 7'(CENTI_PER_SEC - 1));
  assign min_tick = sec_tick && (sec_r == 6'(SEC_PER_MIN - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Shared conditions
  logic sp_pos, ramp_cut;
  // [RQ5] heating direction only on a ramp
  assign sp_pos = i_profile_ramping && i_sp_rising;
  // [RQ3] cutoff temperature while heating
  assign ramp_cut = sp_pos && ($signed(i_temp) >= $signed(cutoff_r[CUT_LSB +: TEMP_W]));

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel compressors and the low stage share one sequencer form
  crl_pid_s pid [3];
  logic [6:0] on_lvl [3];
  logic [6:0] off_lvl [3];
  logic [2:0] seq_on;
  assign pid[0] = i_chan1;
  assign pid[1] = i_chan2;
  assign pid[2] = i_chan1;
  assign on_lvl[0] = chan_lvl_r[LVL_ON_LSB +: PCT_W];
  assign on_lvl[1] = chan_lvl_r[LVL_ON_LSB +: PCT_W];
  assign on_lvl[2] = stage_lvl_r[LVL_ON_LSB +: PCT_W];
  assign off_lvl[0] = chan_lvl_r[LVL_OFF_LSB +: PCT_W];
  assign off_lvl[1] = chan_lvl_r[LVL_OFF_LSB +: PCT_W];
  assign off_lvl[2] = stage_lvl_r[LVL_OFF_LSB +: PCT_W];

  for (genvar g = 0; g < 3; g++) begin : g_seq
    crl_comp_e st_r;
    logic [2:0] min_r;
    logic on_c, off_c;
    // [RQ1] [RQ7] cooling turn-on level
    assign on_c = pid[g].cool_pct >= on_lvl[g];
    // [RQ2] [RQ8] heating turn-off level or ramp cutoff
    assign off_c = (pid[g].heat_pct >= off_lvl[g]) || ramp_cut;

    // [RQ6] on wins; [RQ4] minutes of hold before off
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        st_r <= COMP_OFF;
      end else begin
        unique case (st_r)
          COMP_OFF: if (on_c) st_r <= COMP_RUN;
          COMP_RUN: if (!on_c && off_c) st_r <= (off_delay_min == 3'h0) ? COMP_OFF : COMP_HOLD;
          COMP_HOLD: begin
            if (on_c) begin
              st_r <= COMP_RUN;
            end else if (min_r >= off_delay_min) begin
              st_r <= COMP_OFF;
            end
          end
        endcase
      end
    end

    // [RQ9] low stage off-delay timer cleared while cooling above zero
    always_ff @(posedge i_clock) begin
      if (i_rst || st_r != COMP_HOLD || (g == 2 && pid[g].cool_pct != 7'h00)) begin
        min_r <= 3'h0;
      end else if (min_tick && min_r != 3'h7) begin
        min_r <= min_r + 3'h1;
      end
    end
    assign seq_on[g] = (st_r != COMP_OFF);
  end

  //////////////////////////////////////////////////////////////////////////////
  // High stage and cascade condenser
  logic hs_req, cc_need, cc_off;
  logic [5:0] hs_sec_r;
  logic cc_r;
  logic [2:0] cc_min_r;

  // [RQ11] pressure switch gates when cut-in closed
  assign hs_req = seq_on[2] && (!cutin || press_ok);
  // [RQ12] liquid feed when cooling is needed and the pressure switch gate passes
  assign cc_need = (i_chan1.cool_pct != 7'h00) && (!cutin || press_ok);
  assign cc_off = (i_chan1.heat_pct >= stage_lvl_r[LVL_OFF_LSB +: PCT_W]) || ramp_cut;

  // [RQ10] one-minute turn-on timer, reset while off
  always_ff @(posedge i_clock) begin
    if (i_rst || !hs_req) begin
      hs_sec_r <= 6'h00;
    end else if (sec_tick && hs_sec_r != 6'(HS_ON_DELAY_S)) begin
      hs_sec_r <= hs_sec_r + 6'h01;
    end
  end

  // [RQ13] off wins; [RQ9] hold timer reset by cooling
  always_ff @(posedge i_clock) begin
    if (i_rst || cc_off) begin
      cc_r <= 1'b0;
      cc_min_r <= 3'h0;
    end else if (cc_need) begin
      cc_r <= 1'b1;
      cc_min_r <= 3'h0;
    end else if (i_chan1.cool_pct != 7'h00) begin
      // Cooling demand holds the timer even while the switch gates the feed
      cc_min_r <= 3'h0;
    end else if (cc_r && cc_min_r >= off_delay_min) begin
      cc_r <= 1'b0;
    end else if (cc_r && min_tick) begin
      cc_min_r <= cc_min_r + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boost cool timer
  logic [7:0] boost_sec_r;
  logic boost_mode;
  assign boost_mode = mode_r[MODE_BOOST_BIT];

  // [RQ18] held in reset below full cooling
  always_ff @(posedge i_clock) begin
    if (i_rst || i_chan1.cool_pct < PCT_FULL) begin
      boost_sec_r <= 8'h00;
    end else if (sec_tick && boost_sec_r != 8'hff) begin
      boost_sec_r <= boost_sec_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Humidify and ambient time proportioning
  logic hum_tp, amb_tp, amb_lvl_on_r, amb_heat;
  logic [5:0] amb_cyc;

  // [RQ19] humidify cycle time
  crl_tp u_hum_tp (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_centi(centi_tick),
    .i_cycle_s(cycle_r[CYC_HUM_LSB +: CYC_W]),
    .i_pct(i_humid_pct),
    .o_on(hum_tp)
  );

  // [RQ22] heat cycle while channel 2 heats, else cool cycle
  assign amb_heat = i_chan2.heat_pct != 7'h00;
  assign amb_cyc = amb_heat ? cycle_r[CYC_AHEAT_LSB +: CYC_W] : cycle_r[CYC_ACOOL_LSB +: CYC_W];
  crl_tp u_amb_tp (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_centi(centi_tick),
    .i_cycle_s(amb_cyc),
    .i_pct(i_chan2.cool_pct),
    .o_on(amb_tp)
  );

  // [RQ21] ambient enable from its own levels, on wins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      amb_lvl_on_r <= 1'b0;
    end else if (i_chan2.cool_pct >= amb_lvl_r[LVL_ON_LSB +: PCT_W]) begin
      amb_lvl_on_r <= 1'b1;
    end else if (i_chan2.heat_pct >= amb_lvl_r[LVL_OFF_LSB +: PCT_W] || ramp_cut) begin
      amb_lvl_on_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_compressor <= 2'h0;
      o_low_stage <= 1'b0;
      o_high_stage <= 1'b0;
      o_cascade_cond <= 1'b0;
      o_vacuum <= 1'b0;
      o_vent_boost <= 1'b0;
      o_humidify <= 1'b0;
      o_ambient <= 1'b0;
      o_low_art_load <= 1'b0;
    end else begin
      o_compressor <= seq_on[1:0];
      o_low_stage <= seq_on[2];
      // [RQ10] energise only after the full minute
      o_high_stage <= hs_req && (hs_sec_r == 6'(HS_ON_DELAY_S));
      o_cascade_cond <= cc_r;
      // [RQ14] [RQ15] vacuum logic or event level two
      o_vacuum <= mode_r[MODE_PURGE_BIT] ? mode_r[MODE_LEV2_BIT] : i_vacuum_req;
      // [RQ16] [RQ17] vent request or delayed boost cool
      o_vent_boost <= boost_mode ? (i_chan1.cool_pct >= PCT_FULL && boost_sec_r >= boost_delay_s)
                                 : i_vent_req;
      o_humidify <= hum_tp;
      // [RQ20] proportioned or plain on/off
      o_ambient <= amb_lvl_on_r && (mode_r[MODE_AMB_TP_BIT] ? amb_tp : 1'b1);
      // [RQ24] inverse of PID cool
      o_low_art_load <= !i_pid_cool;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_chan_on_wins: assert property ( // [RQ6]
    (i_chan1.cool_pct >= chan_lvl_r[6:0]) |=> ##1 o_compressor[0])
    else $error("channel 1 compressor not on at turn-on level");
  a_chan_off_now: assert property ( // [RQ2]
    (g_seq[0].st_r == COMP_RUN && !g_seq[0].on_c && g_seq[0].off_c && off_delay_min == 3'h0)
      |=> ##1 !o_compressor[0])
    else $error("compressor did not stop with zero delay");
  a_ramp_gate: assert property ( // [RQ5]
    (g_seq[0].st_r == COMP_RUN && !i_profile_ramping
      && i_chan1.heat_pct < chan_lvl_r[LVL_OFF_LSB +: PCT_W]) |=> (g_seq[0].st_r == COMP_RUN))
    else $error("compressor stopped by ramp cutoff without a ramp");
  a_low_timer_rst: assert property ( // [RQ9]
    (i_chan1.cool_pct != 7'h00) |=> (g_seq[2].min_r == 3'h0))
    else $error("low stage off timer not held in reset");
  a_high_hold: assert property ( // [RQ10]
    $rose(hs_req) |=> !o_high_stage [*8])
    else $error("high stage energised before its delay");
  a_cond_off_wins: assert property ( // [RQ13]
    cc_off |=> ##1 !o_cascade_cond)
    else $error("cascade condenser on while off request");
  a_vac_purge: assert property ( // [RQ15]
    mode_r[MODE_PURGE_BIT] |=> (o_vacuum == $past(mode_r[MODE_LEV2_BIT])))
    else $error("purge does not follow event level two");
  a_boost_reset: assert property ( // [RQ18]
    (boost_mode && i_chan1.cool_pct < PCT_FULL) |=> !o_vent_boost)
    else $error("boost cool on below full cooling");
  a_low_load_inv: assert property ( // [RQ24]
    !$past(i_rst) |-> (o_low_art_load == !$past(i_pid_cool)))
    else $error("low artificial load not inverse of PID cool");

endmodule : crl_output_logic

`default_nettype wire

// ==== tb/crl_contacts.sv ====
// Model of the chamber cut-in contact and the pressure switch
`timescale 1ns/1ps
`default_nettype none

module crl_contacts (
  input wire logic i_cutin_cmd,
  input wire logic i_press_cmd,
  output logic o_cutin_closed,
  output logic o_pressure_ok
);
  // contact levels settle
  // Starts open, then settles a few ns after each command, off the clock edge
  initial begin
    o_cutin_closed = 1'b0;
    forever begin
      @(i_cutin_cmd);
      o_cutin_closed <= #3 i_cutin_cmd;
    end
  end

  // Pressure switch follows its command the same way
  initial begin
    o_pressure_ok = 1'b0;
    forever begin
      @(i_press_cmd);
      o_pressure_ok <= #3 i_press_cmd;
    end
  end
endmodule : crl_contacts

`default_nettype wire

// ==== tb/tb_crl_output_logic.sv ====
// Self-checking bench for the refrigeration output logic
`timescale 1ns/1ps
`default_nettype none

module tb_crl_output_logic;
  import crl_pkg::*;
  localparam int CC = 10;
  localparam int SEC = CC * CENTI_PER_SEC;
  localparam int MIN = SEC * SEC_PER_MIN;
  localparam int LIMIT = 90000;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  crl_pid_s i_chan1 = '0;
  crl_pid_s i_chan2 = '0;
  logic [PCT_W-1:0] i_humid_pct = '0;
  logic [TEMP_W-1:0] i_temp = '0;
  logic i_profile_ramping = 1'b0;
  logic i_sp_rising = 1'b0;
  logic i_pid_cool = 1'b0;
  logic i_vacuum_req = 1'b0;
  logic i_vent_req = 1'b0;
  logic cutin_cmd = 1'b0;
  logic press_cmd = 1'b0;
  logic cutin_closed;
  logic pressure_ok;
  logic [1:0] o_compressor;
  logic o_low_stage, o_high_stage, o_cascade_cond, o_vacuum;
  logic o_vent_boost, o_humidify, o_ambient, o_low_art_load;
  logic [9:0] outs;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] ofs [7] = '{OFS_CHAN_LVL, OFS_STAGE_LVL, OFS_AMB_LVL, OFS_CUTOFF, OFS_DELAY,
    OFS_CYCLE, OFS_MODE};
  logic [31:0] rst_v [7] = '{RST_CHAN_LVL, RST_STAGE_LVL, RST_AMB_LVL, RST_CUTOFF, RST_DELAY,
    RST_CYCLE, RST_MODE};
  logic [31:0] msk [7] = '{MASK_LVL, MASK_LVL, MASK_LVL, MASK_CUTOFF, MASK_DELAY, MASK_CYCLE,
    MASK_MODE};

  // Outputs gathered in status register order
  assign outs = {o_low_art_load, o_ambient, o_humidify, o_vent_boost, o_vacuum, o_cascade_cond,
    o_high_stage, o_low_stage, o_compressor};

  // Design and contact model
  crl_output_logic #(.CENTI_CYC(CC)) crl_output_logic_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_chan1(i_chan1), .i_chan2(i_chan2),
    .i_humid_pct(i_humid_pct), .i_temp(i_temp), .i_profile_ramping(i_profile_ramping),
    .i_sp_rising(i_sp_rising), .i_pid_cool(i_pid_cool), .i_vacuum_req(i_vacuum_req),
    .i_vent_req(i_vent_req), .i_cutin_closed(cutin_closed), .i_pressure_ok(pressure_ok),
    .o_compressor(o_compressor), .o_low_stage(o_low_stage), .o_high_stage(o_high_stage),
    .o_cascade_cond(o_cascade_cond), .o_vacuum(o_vacuum), .o_vent_boost(o_vent_boost),
    .o_humidify(o_humidify), .o_ambient(o_ambient), .o_low_art_load(o_low_art_load));
  crl_contacts crl_contacts_i (.i_cutin_cmd(cutin_cmd), .i_press_cmd(press_cmd),
    .o_cutin_closed(cutin_closed), .o_pressure_ok(pressure_ok));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation
  initial begin
    forever #5 i_clock = ~i_clock;
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      results();
    end
  end

  // Verdict and end of run
  task automatic results;
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Let n edges pass, then step off the edge
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_n

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // One-cycle register read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd

  // PID pair from percentages
  function automatic crl_pid_s pid(input int c, input int h);
    return '{cool_pct: 7'(c), heat_pct: 7'(h)};
  endfunction : pid

  // Apply one PID and temperature state to both channels, then check masked outputs
  task automatic step(input int c, input int h, input logic rmp, input logic rise, input int t,
    input logic [9:0] m, input logic [9:0] e);
    @(posedge i_clock);
    i_chan1 <= pid(c, h);
    i_chan2 <= pid(c, h);
    i_profile_ramping <= rmp;
    i_sp_rising <= rise;
    i_temp <= 8'(t);
    wait_n(6);
    chk(32'(outs & m), 32'(e));
  endtask : step

  // Count on-cycles of one output over one second, after a settling second
  task automatic count_on(input int idx, input int exp);
    int n = 0;
    wait_n(SEC);
    repeat (SEC) begin
      @(posedge i_clock);
      #1;
      if (outs[idx] === 1'b1) n++;
    end
    chk(32'(n), 32'(exp));
  endtask : count_on

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    #1;
    chk(32'(outs), 32'h0);
    // Reset values, writable bits, restore
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], rst_v[i]);
      wr(ofs[i], '1);
      rd(ofs[i], msk[i]);
      wr(ofs[i], rst_v[i]);
    end
    wr(8'h20, '1);
    rd(8'h20, 32'h0);
    wr(OFS_STATUS, '1);
    rd(OFS_STATUS, 32'h200); // inverse of cool
    wr(OFS_DELAY, 32'h0000_0200);
    // Single compressors and ambient on/off
    step(9, 0, 0, 0, 0, 10'h103, 10'h000); // below on level
    step(10, 0, 0, 0, 0, 10'h103, 10'h103); // on level
    step(0, 49, 0, 0, 0, 10'h103, 10'h103); // below off level
    step(0, 50, 0, 0, 0, 10'h103, 10'h000); // off, zero delay
    step(10, 50, 0, 0, 0, 10'h003, 10'h003); // on wins
    step(0, 0, 0, 1, 60, 10'h003, 10'h003); // rising without profile
    step(0, 0, 1, 1, 49, 10'h003, 10'h003); // below cutoff
    step(0, 0, 1, 1, 50, 10'h003, 10'h000); // cutoff reached
    // Low stage and cascade condenser
    step(0, 80, 0, 0, 0, 10'h014, 10'h000); // start off
    step(19, 0, 0, 0, 0, 10'h014, 10'h010); // need turns condenser on
    step(20, 0, 0, 0, 0, 10'h014, 10'h014); // low stage on
    step(0, 79, 0, 0, 0, 10'h014, 10'h004); // below off level
    step(0, 80, 0, 0, 0, 10'h014, 10'h000); // off level
    step(20, 80, 0, 0, 0, 10'h014, 10'h004); // priorities differ
    // Vacuum, vent and low artificial load
    @(posedge i_clock);
    i_vacuum_req <= 1'b1;
    i_vent_req <= 1'b1;
    i_pid_cool <= 1'b1;
    wait_n(4);
    chk(32'(outs & 10'h260), 32'h060); // default types
    wr(OFS_MODE, 32'h1);
    wait_n(4);
    chk(32'(outs & 10'h020), 32'h000); // purge ignores vacuum logic
    wr(OFS_MODE, 32'h9);
    @(posedge i_clock);
    i_vacuum_req <= 1'b0;
    i_vent_req <= 1'b0;
    wait_n(4);
    chk(32'(outs & 10'h060), 32'h020); // event level drives
    // Boost cool with a 2 s delay
    wr(OFS_MODE, 32'h2);
    step(99, 0, 0, 0, 0, 10'h040, 10'h000);
    wait_n(3 * SEC);
    chk(32'(outs & 10'h040), 32'h000); // below full cooling
    step(100, 0, 0, 0, 0, 10'h040, 10'h000);
    wait_n(SEC - 100);
    chk(32'(outs & 10'h040), 32'h000); // not yet elapsed
    wait_n(SEC + 200);
    chk(32'(outs & 10'h040), 32'h040); // elapsed
    step(99, 0, 0, 0, 0, 10'h040, 10'h000); // timer reset
    // Time-proportioned humidify and ambient
    @(posedge i_clock);
    i_humid_pct <= 7'd50;
    count_on(7, SEC / 2); // half of a 1 s cycle
    wr(OFS_CYCLE, 32'h0001_0101);
    wr(OFS_MODE, 32'h4);
    @(posedge i_clock);
    i_chan2 <= pid(30, 0);
    count_on(8, SEC * 30 / 100); // ambient proportioned
    // Hold timer, high stage one minute, contact gating
    step(0, 80, 0, 0, 0, 10'h01f, 10'h000); // all off, high stage timer cleared
    wr(OFS_MODE, 32'h0);
    wr(OFS_DELAY, 32'h0000_0201);
    @(posedge i_clock);
    cutin_cmd <= 1'b1;
    press_cmd <= 1'b1;
    step(25, 0, 0, 0, 0, 10'h00f, 10'h007); // low stage and compressors on
    step(1, 80, 0, 0, 0, 10'h014, 10'h004); // held on
    wait_n(MIN - 2000);
    chk(32'(outs & 10'h008), 32'h000); // high stage still waiting
    wait_n(3000);
    chk(32'(outs & 10'h00f), 32'h00c); // after a minute
    @(posedge i_clock);
    press_cmd <= 1'b0;
    wait_n(8);
    chk(32'(outs & 10'h00c), 32'h004); // cut-in needs pressure
    results();
  end
endmodule : tb_crl_output_logic

`default_nettype wire
